// *** logic/parallel_io_map.vh ***
// register offsets, field positions and reset values of the two parallel port units
`ifndef PARALLEL_IO_MAP_VH
`define PARALLEL_IO_MAP_VH
`define GIO_BASE          8'h40
`define GIO_WIN_MASK      8'hfc
`define HC_BASE           8'h00
`define HC_WIN_MASK       8'hfc
`define OFS_FIRST         2'h0
`define OFS_SECOND        2'h1
`define OFS_THIRD         2'h2
`define OFS_CTRL          2'h3
`define CTRL_MODE_SET     7
`define CTRL_FIRST_IN     4
`define CTRL_THIRD_HI_IN  3
`define CTRL_SECOND_IN    1
`define CTRL_THIRD_LO_IN  0
`define CTRL_BSR_SET      0
`define CTRL_BSR_SEL_LO   1
`define CTRL_BSR_SEL_HI   3
`define DIR_RESET         1'b1
`define DATA_RESET        8'h00
`define CTRL_RESET        8'h9b
`define COUNT_RESET       16'h0000
`define SEL_COUNT_BIT     1'b0
`define CTRL_COUNT_SRC    2
`define PIN_IDLE          8'hff
`define EDGE_IDLE         2'h3
`define OE_RESET          8'h00
`define SINK_OFF          8'hff
`define RDATA_RESET       8'h00
`endif

// *** logic/dual_parallel_io_ports.v ***
// two parallel port units: a 24-line general port unit and an 8-line inverting high-current unit
//
// What this block does
// - general unit decodes four I/O addresses starting at 40H.
// - first port at offset 0, all eight lines one direction.
// - second port at offset 1, all eight lines one direction.
// - third port at offset 2, direction whole or per four-line half.
// - third port bits 0 and 1 serve as input, output, interrupt or counter.
// - high-current unit at addresses 0 to 3, eight output lines to driver.
// - high-current path inverts: writing 1 turns output on, pulling it low.
// - every line of both units comes up as input after reset.
`timescale 1ns/1ps
`include "parallel_io_map.vh"
module dual_parallel_io_ports #(
	parameter ADDR_WIDTH = 8
) (
	input  wire                  clock,
	input  wire                  resetn,
	input  wire                  enable,
	input  wire [ADDR_WIDTH-1:0] io_addr,
	input  wire                  io_read,
	input  wire                  io_write,
	input  wire [7:0]            io_wdata,
	output reg  [7:0]            io_rdata,
	input  wire [7:0]            first_in,
	output reg  [7:0]            first_out,
	output reg  [7:0]            first_oe,
	input  wire [7:0]            second_in,
	output reg  [7:0]            second_out,
	output reg  [7:0]            second_oe,
	input  wire [7:0]            third_in,
	output reg  [7:0]            third_out,
	output reg  [7:0]            third_oe,
	output reg  [1:0]            third_irq,
	output reg  [15:0]           event_count,
	output reg  [7:0]            sink_drive_n,
	output reg                   sink_enable,
	output reg  [7:0]            hc_pin_out,
	output reg  [7:0]            hc_oe,
	input  wire [7:0]            hc_pin_in
);

	// pin synchronisers, two stages, second stage only read by logic;
	// the first stage may go metastable, so nothing else looks at it
	reg [7:0]  first_s1, first_s2;
	reg [7:0]  second_s1, second_s2;
	reg [7:0]  third_s1, third_s2;
	reg [7:0]  hc_s1, hc_s2;
	// last sampled level of third port bits 0/1, for edge detection
	reg [1:0]  third_prev;
	// general unit state
	reg [7:0]  first_latch, second_latch, third_latch;
	reg        first_dir_in, second_dir_in, third_lo_in, third_hi_in;
	reg        count_src;
	// high-current unit state; only its first port reaches pins, so the
	// rest of its control byte has nothing to steer and is not kept
	reg [7:0]  hc_latch;
	reg        hc_dir_in;

	// address decode: both windows are four bytes wide and aligned,
	// so the low two address bits pick the location inside a window
	wire [7:0] full_addr = io_addr[7:0];
	wire       gio_sel = ((full_addr & `GIO_WIN_MASK) == `GIO_BASE);
	wire       hc_sel  = ((full_addr & `HC_WIN_MASK) == `HC_BASE);
	wire [1:0] ofs     = full_addr[1:0];
	wire       gio_wr  = enable & io_write & gio_sel;
	wire       hc_wr   = enable & io_write & hc_sel;
	// rising edges of third port bits 0/1, seen after synchronisation
	wire [1:0] rise    = third_s2[1:0] & ~third_prev;
	// control byte: bit 7 high is a mode write, bit 7 low a single-bit
	// set or reset of the third port, bits 3:1 naming the bit, bit 0 its value
	wire [2:0] bsr_bit = io_wdata[`CTRL_BSR_SEL_HI:`CTRL_BSR_SEL_LO];

	// synchronise every pin input before use
	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			// idle level of the pulled-up lines, so no false edge after reset
			first_s1   <= `PIN_IDLE;
			first_s2   <= `PIN_IDLE;
			second_s1  <= `PIN_IDLE;
			second_s2  <= `PIN_IDLE;
			third_s1   <= `PIN_IDLE;
			third_s2   <= `PIN_IDLE;
			hc_s1      <= `PIN_IDLE;
			hc_s2      <= `PIN_IDLE;
			third_prev <= `EDGE_IDLE;
		end else if (enable) begin
			first_s1   <= first_in;
			first_s2   <= first_s1;
			second_s1  <= second_in;
			second_s2  <= second_s1;
			third_s1   <= third_in;
			third_s2   <= third_s1;
			hc_s1      <= hc_pin_in;
			hc_s2      <= hc_s1;
			third_prev <= third_s2[1:0];
		end
	end

	// general unit: data latches and control register
	// a write with enable low is dropped, since gio_wr already holds enable
	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			first_latch   <= `DATA_RESET;
			second_latch  <= `DATA_RESET;
			third_latch   <= `DATA_RESET;
			first_dir_in  <= `DIR_RESET;
			second_dir_in <= `DIR_RESET;
			third_lo_in   <= `DIR_RESET;
			third_hi_in   <= `DIR_RESET;
			count_src     <= `SEL_COUNT_BIT;
		end else if (gio_wr) begin
			case (ofs)
				`OFS_FIRST:  first_latch  <= io_wdata;
				`OFS_SECOND: second_latch <= io_wdata;
				`OFS_THIRD:  third_latch  <= io_wdata;
				default: begin
					// control write: mode set or single-bit set/reset of third port
					if (io_wdata[`CTRL_MODE_SET]) begin
						first_dir_in  <= io_wdata[`CTRL_FIRST_IN];
						second_dir_in <= io_wdata[`CTRL_SECOND_IN];
						third_lo_in   <= io_wdata[`CTRL_THIRD_LO_IN];
						third_hi_in   <= io_wdata[`CTRL_THIRD_HI_IN];
						// a mode write clears the latches so no stale byte drives a new output
						first_latch   <= `DATA_RESET;
						second_latch  <= `DATA_RESET;
						third_latch   <= `DATA_RESET;
						// bit 2 selects which low line of the third port feeds the counter
						count_src     <= io_wdata[`CTRL_COUNT_SRC];
					end else begin
						third_latch[bsr_bit] <= io_wdata[`CTRL_BSR_SET];
					end
				end
			endcase
		end
	end

	// third port bits 0/1: interrupt on rising input edge, counter on chosen line
	// edges count only while the lower half is input; an output raises nothing
	// counter wraps silently at 16 bits, software must read it often enough
	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			third_irq   <= 2'h0;
			event_count <= `COUNT_RESET;
		end else if (enable) begin
			third_irq <= third_lo_in ? rise : 2'h0;
			if (third_lo_in && rise[count_src]) begin
				event_count <= event_count + 16'h0001;
			end
		end
	end

	// high-current unit: latch and control, first port only wired to pins
	// a control byte with bit 7 low is dropped: this unit has no third port
	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			hc_latch      <= `DATA_RESET;
			hc_dir_in     <= `DIR_RESET;
		end else if (hc_wr) begin
			if (ofs == `OFS_FIRST) begin
				hc_latch <= io_wdata;
			end else if (ofs == `OFS_CTRL && io_wdata[`CTRL_MODE_SET]) begin
				hc_dir_in     <= io_wdata[`CTRL_FIRST_IN];
				hc_latch      <= `DATA_RESET;
			end
		end
	end

	// registered pin drives and output enables for both units
	// pins follow the latches one edge late: the price of outputs straight from flops
	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			// everything released and every sink off while reset is held
			first_out    <= `DATA_RESET;
			first_oe     <= `OE_RESET;
			second_out   <= `DATA_RESET;
			second_oe    <= `OE_RESET;
			third_out    <= `DATA_RESET;
			third_oe     <= `OE_RESET;
			hc_pin_out   <= `DATA_RESET;
			hc_oe        <= `OE_RESET;
			sink_drive_n <= `SINK_OFF;
			sink_enable  <= 1'b0;
		end else if (enable) begin
			first_out  <= first_latch;
			first_oe   <= {8{~first_dir_in}};
			second_out <= second_latch;
			second_oe  <= {8{~second_dir_in}};
			third_out  <= third_latch;
			third_oe   <= {{4{~third_hi_in}}, {4{~third_lo_in}}};
			hc_pin_out <= hc_latch;
			hc_oe      <= {8{~hc_dir_in}};
			// inverting sink: a 1 written pulls the load pin low; input mode leaves it off
			sink_drive_n <= hc_dir_in ? 8'hff : ~hc_latch;
			sink_enable  <= ~hc_dir_in;
		end
	end

	// read mux; control location is write-only and reads zero
	// a read answers one edge later; input ports give pins two edges behind
	// high-current offsets 1 to 3 read zero, only its first port exists
	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			io_rdata <= `RDATA_RESET;
		end else if (enable && io_read) begin
			if (gio_sel) begin
				case (ofs)
					`OFS_FIRST:  io_rdata <= first_dir_in ? first_s2 : first_latch;
					`OFS_SECOND: io_rdata <= second_dir_in ? second_s2 : second_latch;
					`OFS_THIRD:  io_rdata <= {third_hi_in ? third_s2[7:4] : third_latch[7:4],
					                          third_lo_in ? third_s2[3:0] : third_latch[3:0]};
					default:     io_rdata <= 8'h00;
				endcase
			end else if (hc_sel && ofs == `OFS_FIRST) begin
				io_rdata <= hc_dir_in ? hc_s2 : hc_latch;
			end else begin
				io_rdata <= 8'h00;
			end
		end
	end

endmodule

// *** verif/io_ports_checker.sv ***
// concurrent checks on the dual parallel port block
`timescale 1ns/1ps
module io_ports_checker #(
	parameter ADDR_WIDTH = 8
) (
	input wire                  clock, resetn, enable, io_read, io_write, sink_enable,
	input wire [ADDR_WIDTH-1:0] io_addr,
	input wire [7:0]            io_wdata, io_rdata, first_out, first_oe, second_oe, third_oe, sink_drive_n, hc_pin_out
);
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	// a latch write, then an edge where its unit takes no write
	sequence wr(a, ok);
		enable && io_write && io_addr == a && ok;
	endsequence
	sequence quiet(hi);
		enable && !(io_write && io_addr[7:2] == hi);
	endsequence
	rst_inputs_a: assert property ($rose(resetn) |-> {first_oe, second_oe, third_oe, sink_enable} == 25'h0)
		else $error("not inputs");
	first_dir_a: assert property (first_oe == 8'h00 || first_oe == 8'hff) else $error("first split");
	second_dir_a: assert property (second_oe == 8'h00 || second_oe == 8'hff) else $error("second split");
	third_half_a: assert property ((third_oe[3:0] == 4'h0 || third_oe[3:0] == 4'hf) &&
		(third_oe[7:4] == 4'h0 || third_oe[7:4] == 4'hf)) else $error("third split");
	sink_invert_a: assert property (sink_enable |-> sink_drive_n == ~hc_pin_out) else $error("no invert");
	first_wr_a: assert property (wr(8'h40, first_oe == 8'hff) ##1 quiet(6'h10) |=> first_out == $past(io_wdata, 2))
		else $error("first out");
	sink_wr_a: assert property (wr(8'h00, sink_enable) ##1 quiet(6'h00) |=> sink_drive_n == ~$past(io_wdata, 2))
		else $error("sink drive");
	blank_read_a: assert property (enable && io_read && (io_addr == 8'h43 || io_addr == 8'h80) |=> io_rdata == 8'h00)
		else $error("read not zero");
endmodule
bind dual_parallel_io_ports io_ports_checker #(.ADDR_WIDTH(ADDR_WIDTH)) u_io_ports_checker (.*);

// *** verif/far_side_port.sv ***
// switches and loads on one eight-line port
`timescale 1ns/1ps
module far_side_port (
	input  wire [7:0] oe,
	input  wire [7:0] drive,
	input  wire [7:0] sw,
	output wire [7:0] pin
);
	// a released line shows its switch, never the last driven value
	assign pin = (oe & drive) | (~oe & sw);
endmodule

// *** verif/tb_dual_parallel_io_ports.sv ***
// self-checking bench for the dual parallel port block
`timescale 1ns/1ps
module tb_dual_parallel_io_ports;
	reg         clock = 1'b0, resetn = 1'b0, enable = 1'b1, io_read = 1'b0, io_write = 1'b0;
	reg  [7:0]  io_addr = 8'h00, io_wdata = 8'h00, sw1 = 8'h00, sw2 = 8'h00, sw3 = 8'h00, d;
	reg  [23:0] v;
	wire [7:0]  io_rdata, o1, e1, o2, e2, o3, e3, oh, eh, p1, p2, p3, ph, sink_drive_n;
	wire [15:0] event_count;
	wire [1:0]  third_irq;
	wire        sink_enable;
	integer     fails = 0, n_compared = 0, i;
	always #2.5 clock = ~clock;
	dual_parallel_io_ports u_dual_parallel_io_ports (.clock(clock), .resetn(resetn), .enable(enable),
		.io_addr(io_addr), .io_read(io_read), .io_write(io_write), .io_wdata(io_wdata), .io_rdata(io_rdata),
		.first_in(p1), .first_out(o1), .first_oe(e1), .second_in(p2), .second_out(o2), .second_oe(e2),
		.third_in(p3), .third_out(o3), .third_oe(e3), .third_irq(third_irq), .event_count(event_count),
		.sink_drive_n(sink_drive_n), .sink_enable(sink_enable), .hc_pin_out(oh), .hc_oe(eh), .hc_pin_in(ph));
	far_side_port u_far_side_port_a (.oe(e1), .drive(o1), .sw(sw1), .pin(p1));
	far_side_port u_far_side_port_b (.oe(e2), .drive(o2), .sw(sw2), .pin(p2));
	far_side_port u_far_side_port_c (.oe(e3), .drive(o3), .sw(sw3), .pin(p3));
	far_side_port u_far_side_port_h (.oe(eh), .drive(oh), .sw(8'hff), .pin(ph));
	// driven bits read back the latch, released bits the pins
	function [7:0] mix(input [7:0] latch, input [7:0] pins, input [7:0] oe);
		mix = (latch & oe) | (pins & ~oe);
	endfunction
	task chk(input [23:0] seen, input [23:0] exp);
		begin
			n_compared = n_compared + 1;
			if (seen !== exp) begin
				fails = fails + 1;
				$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
			end
		end
	endtask
	// strobe stays high across back-to-back writes
	task wr(input [7:0] a, input [7:0] w);
		begin
			io_read = 1'b0;
			io_addr = a;
			io_wdata = w;
			io_write = 1'b1;
			@(negedge clock);
		end
	endtask
	task idle(input integer n);
		begin
			io_write = 1'b0;
			io_read = 1'b0;
			repeat (n) @(negedge clock);
		end
	endtask
	task rd(input [7:0] a, input [7:0] e);
		begin
			io_write = 1'b0;
			io_addr = a;
			io_read = 1'b1;
			@(negedge clock);
			chk(io_rdata, e);
		end
	endtask
	task wrap_up;
		begin
			$display("compared %0d, mismatches %0d", n_compared, fails);
			if (fails == 0 && n_compared > 0)
				$display("All tests passed");
			else
				$display("Some tests failed");
			$finish;
		end
	endtask
	initial begin
		i = $urandom(35054);
		repeat (5) @(negedge clock);
		resetn = 1'b1;
		chk({e1, e2, e3}, 24'h0);
		chk({sink_enable, eh}, 24'h0);
		idle(3);
		chk({third_irq, event_count}, 24'h0);
		sw3 = 8'h01;
		idle(3);
		chk(third_irq, 24'h1);
		chk(event_count, 24'h1);
		idle(1);
		chk(third_irq, 24'h0);
		wr(8'h43, 8'h85);
		sw3 = 8'h03;
		idle(3);
		chk(third_irq, 24'h2);
		chk(event_count, 24'h2);
		$display("reset and counter done");
		wr(8'h43, 8'h80);
		for (i = 0; i < 4; i = i + 1) begin
			v = $urandom;
			wr(8'h42, v[7:0]);
			wr(8'h41, v[15:8]);
			wr(8'h40, v[23:16]);
			idle(3);
			chk({p1, p2, p3}, v);
			rd(8'h41, v[15:8]);
		end
		// a write while enable is low must leave the first port alone
		enable = 1'b0;
		wr(8'h40, ~v[23:16]);
		idle(2);
		enable = 1'b1;
		idle(3);
		chk(p1, v[23:16]);
		sw3 = $urandom;
		d = $urandom;
		wr(8'h43, 8'h81);
		wr(8'h42, d);
		idle(3);
		chk(e3, 24'hf0);
		rd(8'h42, mix(d, sw3, 8'hf0));
		sw1 = $urandom;
		sw2 = $urandom;
		wr(8'h43, 8'h9b);
		idle(4);
		rd(8'h40, sw1);
		rd(8'h41, sw2);
		rd(8'h43, 8'h00);
		rd(8'h80, 8'h00);
		$display("general unit done");
		wr(8'h03, 8'h80);
		idle(3);
		d = 8'h01;
		wr(8'h00, d);
		idle(3);
		chk({sink_enable, sink_drive_n}, {1'b1, ~d});
		rd(8'h00, d);
		// reset in mid-run: every line back to input, every sink off
		resetn = 1'b0;
		idle(2);
		chk({e1, e2, e3}, 24'h0);
		chk({sink_enable, eh, sink_drive_n}, {9'h000, 8'hff});
		resetn = 1'b1;
		idle(2);
		$display("sink unit done");
		wrap_up;
	end
endmodule
